// ==== rtl/facp_pkg.sv ====
// facp_pkg: shared constants and types of the flash access permission check
// assumes: included before every design file of the block
package facp_pkg;

  // ----------------------------------------
  // protection levels, sources, areas, ops
  // ----------------------------------------
  typedef enum logic [1:0] {FACP_LVL_LOW, FACP_LVL_MID, FACP_LVL_HIGH} facp_level_t;
  typedef enum logic [1:0] {FACP_SRC_DEBUG, FACP_SRC_MAIN, FACP_SRC_SYSMEM, FACP_SRC_SRAM}
    facp_source_t;
  typedef enum logic [2:0] {FACP_AREA_MAIN, FACP_AREA_MASS, FACP_AREA_OPT, FACP_AREA_SYS,
    FACP_AREA_SRAM} facp_area_t;
  typedef enum logic [1:0] {FACP_OP_READ, FACP_OP_PROG, FACP_OP_PAGE_ERASE} facp_op_t;

  // ----------------------------------------
  // option byte values and address layout
  // ----------------------------------------
  localparam logic [7:0]  FACP_HIGH_BYTE      = 8'hcc;
  localparam logic [7:0]  FACP_HIGH_BYTE_CMP  = 8'h33;
  localparam logic [7:0]  FACP_LOW_BYTE       = 8'ha5;
  localparam int          FACP_ADDR_W         = 32;
  localparam logic [31:0] FACP_FIRST_4KB_SIZE = 32'h0000_1000;

endpackage

// ==== rtl/facp_rule_check.sv ====
// facp_rule_check: combinational permission decision for one access
// assumes: level, source and area are already stable in the requesting cycle
`timescale 1ns/1ps
`default_nettype none
module facp_rule_check (
  input  wire facp_pkg::facp_level_t  level,
  input  wire facp_pkg::facp_source_t source,
  input  wire facp_pkg::facp_area_t   area,
  input  wire facp_pkg::facp_op_t     op,
  input  wire logic                   in_first_4kb,
  output logic                        allow
);

  always_comb
  begin
    allow = 1'b0;
    case (area)
      facp_pkg::FACP_AREA_SRAM: allow = 1'b1; // R14
      facp_pkg::FACP_AREA_SYS:  allow = (source == facp_pkg::FACP_SRC_SYSMEM); // R05
      facp_pkg::FACP_AREA_MASS:
        // no debug reaches anything but SRAM once the port is fused off
        allow = !(level == facp_pkg::FACP_LVL_HIGH && source == facp_pkg::FACP_SRC_DEBUG); // R03 R09
      facp_pkg::FACP_AREA_OPT:
        if (level == facp_pkg::FACP_LVL_HIGH)
        begin
          allow = (op == facp_pkg::FACP_OP_READ) && (source != facp_pkg::FACP_SRC_DEBUG); // R04 R09
        end
        else
        begin
          allow = 1'b1; // R04
        end
      facp_pkg::FACP_AREA_MAIN:
        if (level == facp_pkg::FACP_LVL_LOW)
        begin
          allow = 1'b1; // R01
        end
        else if (source == facp_pkg::FACP_SRC_DEBUG)
        begin
          allow = 1'b0; // R02 R09
        end
        else
        begin
          // erase here is always page erase; mass erase has its own area
          allow = !in_first_4kb || (op == facp_pkg::FACP_OP_READ); // R02 R10
        end
      default: allow = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ==== rtl/facp_level_decode.sv ====
// facp_level_decode: derives the protection level from the option bytes
// assumes: option bytes are held stable by the loader between reloads
`timescale 1ns/1ps
`default_nettype none
module facp_level_decode (
  input  wire logic [7:0]          read_protect_byte_one,
  input  wire logic [7:0]          read_protect_byte_two,
  input  wire logic [7:0]          read_protect_byte_two_complement,
  output facp_pkg::facp_level_t    level
);

  always_comb
  begin
    if (read_protect_byte_two == facp_pkg::FACP_HIGH_BYTE &&
        read_protect_byte_two_complement == facp_pkg::FACP_HIGH_BYTE_CMP)
    begin
      level = facp_pkg::FACP_LVL_HIGH; // R11
    end
    else if (read_protect_byte_one == facp_pkg::FACP_LOW_BYTE)
    begin
      level = facp_pkg::FACP_LVL_LOW;
    end
    else
    begin
      level = facp_pkg::FACP_LVL_MID;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/facp_top.sv ====
// facp_top: flash access permission check and protection level control
// assumes: a flash controller behind it performs granted operations and
// reports done; requests are held until answered.
//
// Overview of operation
// (R01) lowest level: main array fully open everywhere
// (R02) middle: no debug; first 4KB read-only
// (R03) mass erase allowed at lowest and middle
// (R04) option bytes open, read-only at highest
// (R05) system memory only from system memory code
// (R06) lowest may move to middle or highest
// (R07) middle may move to lowest or highest
// (R08) lowering to lowest erases whole main array
// (R09) highest: no level change, debug disabled
// (R10) non-mass erase means page erase
// (R11) second byte 0xcc, complement 0x33 means highest
// (R12) after downgrade erase, rewrite first byte 0xa5
// (R13) forbidden access blocked, error flag raised
// (R14) SRAM always readable and writable
`timescale 1ns/1ps
`default_nettype none
module facp_top #(
  parameter int ADDR_W = facp_pkg::FACP_ADDR_W
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  // access request from bus master or debug port
  input  wire logic                   req_valid,
  input  wire facp_pkg::facp_source_t req_source,
  input  wire facp_pkg::facp_area_t   req_area,
  input  wire facp_pkg::facp_op_t     req_op,
  input  wire logic [ADDR_W-1:0]      req_offset,
  output logic                        req_ready,
  output logic                        req_grant_q,
  output logic                        req_error_q,
  // level change request
  input  wire logic                   lvl_req,
  input  wire facp_pkg::facp_level_t  lvl_target,
  output logic                        lvl_refused_q,
  // option bytes as loaded
  input  wire logic [7:0]             read_protect_byte_one,
  input  wire logic [7:0]             read_protect_byte_two,
  input  wire logic [7:0]             read_protect_byte_two_complement,
  // towards the flash array controller
  output logic                        fl_mass_erase_q,
  output logic                        fl_opt_write_q,
  output logic [7:0]                  fl_opt_data_q,
  output logic                        fl_opt_high_q,
  input  wire logic                   fl_done,
  // state and error to software / debug block
  output facp_pkg::facp_level_t       level_q,
  output logic                        debug_enable_q,
  output logic                        busy_q,
  input  wire logic                   err_clear
);

  typedef enum logic [1:0] {FACP_ST_IDLE, FACP_ST_ERASE, FACP_ST_REWRITE, FACP_ST_RAISE}
    facp_state_t;

  facp_state_t           state_q;
  facp_state_t           state_d;
  facp_pkg::facp_level_t level_dec;
  facp_pkg::facp_level_t level_d;
  logic                  allow;
  logic                  in_first_4kb;
  logic                  grant_d;
  logic                  error_d;
  logic                  refused_d;
  logic                  mass_d;
  logic                  optw_d;
  logic [7:0]            optd_d;
  logic                  opth_d;

  // ----------------------------------------
  // level decode and permission decision
  // ----------------------------------------
  facp_level_decode u_decode (
    .read_protect_byte_one            (read_protect_byte_one),
    .read_protect_byte_two            (read_protect_byte_two),
    .read_protect_byte_two_complement (read_protect_byte_two_complement),
    .level                            (level_dec)
  );

  assign in_first_4kb = (req_offset < facp_pkg::FACP_FIRST_4KB_SIZE[ADDR_W-1:0]);

  facp_rule_check u_check (
    .level        (level_q),
    .source       (req_source),
    .area         (req_area),
    .op           (req_op),
    .in_first_4kb (in_first_4kb),
    .allow        (allow)
  );

  // accesses wait while a downgrade is running
  assign req_ready = (state_q == FACP_ST_IDLE);

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_comb
  begin
    state_d   = state_q;
    level_d   = level_q;
    grant_d   = 1'b0;
    error_d   = req_error_q && !err_clear;
    refused_d = 1'b0;
    mass_d    = 1'b0;
    optw_d    = 1'b0;
    optd_d    = fl_opt_data_q;
    opth_d    = fl_opt_high_q;
    case (state_q)
      FACP_ST_IDLE:
      begin
        // level follows the option bytes while nothing is in flight
        level_d = level_dec;
        if (lvl_req)
        begin
          case (level_q)
            facp_pkg::FACP_LVL_LOW:
              if (lvl_target == facp_pkg::FACP_LVL_LOW)
              begin
                refused_d = 1'b1;
              end
              else
              begin
                optw_d  = 1'b1; // R06
                opth_d  = (lvl_target == facp_pkg::FACP_LVL_HIGH);
                optd_d  = 8'h00;
                state_d = FACP_ST_RAISE;
              end
            facp_pkg::FACP_LVL_MID:
              if (lvl_target == facp_pkg::FACP_LVL_LOW)
              begin
                mass_d  = 1'b1; // R07 R08
                state_d = FACP_ST_ERASE;
              end
              else if (lvl_target == facp_pkg::FACP_LVL_HIGH)
              begin
                optw_d  = 1'b1; // R07
                opth_d  = 1'b1;
                optd_d  = 8'h00;
                state_d = FACP_ST_RAISE;
              end
              else
              begin
                refused_d = 1'b1;
              end
            default: refused_d = 1'b1; // R09
          endcase
        end
        else if (req_valid)
        begin
          grant_d = allow;
          if (!allow)
          begin
            error_d = 1'b1; // R13
          end
        end
      end
      FACP_ST_ERASE:
        // protection stays at middle until the a5 rewrite after the erase completes
        if (fl_done)
        begin
          optw_d  = 1'b1;
          opth_d  = 1'b0;
          optd_d  = facp_pkg::FACP_LOW_BYTE; // R12
          state_d = FACP_ST_REWRITE;
        end
      FACP_ST_REWRITE:
        if (fl_done)
        begin
          level_d = facp_pkg::FACP_LVL_LOW; // R08
          state_d = FACP_ST_IDLE;
        end
      FACP_ST_RAISE:
        if (fl_done)
        begin
          level_d = opth_d ? facp_pkg::FACP_LVL_HIGH : facp_pkg::FACP_LVL_MID;
          state_d = FACP_ST_IDLE;
        end
      default: state_d = FACP_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      // start at the safest level until option bytes are seen
      state_q         <= FACP_ST_IDLE;
      level_q         <= facp_pkg::FACP_LVL_HIGH;
      req_grant_q     <= 1'b0;
      req_error_q     <= 1'b0;
      lvl_refused_q   <= 1'b0;
      fl_mass_erase_q <= 1'b0;
      fl_opt_write_q  <= 1'b0;
      fl_opt_data_q   <= 8'h00;
      fl_opt_high_q   <= 1'b0;
      debug_enable_q  <= 1'b0;
      busy_q          <= 1'b0;
    end
    else
    begin
      state_q         <= state_d;
      level_q         <= level_d;
      req_grant_q     <= grant_d;
      req_error_q     <= error_d;
      lvl_refused_q   <= refused_d;
      fl_mass_erase_q <= mass_d;
      fl_opt_write_q  <= optw_d;
      fl_opt_data_q   <= optd_d;
      fl_opt_high_q   <= opth_d;
      debug_enable_q  <= (level_d != facp_pkg::FACP_LVL_HIGH); // R09
      busy_q          <= (state_d != FACP_ST_IDLE);
    end
  end

endmodule
`default_nettype wire

// ==== verif/facp_chk.sv ====
// facp_chk: port timing checks of facp_top
// assumes: bound into facp_top, single clock domain
`timescale 1ns/1ps
`default_nettype none
module facp_chk (
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   req_valid,
  input wire logic                   req_ready,
  input wire facp_pkg::facp_source_t req_source,
  input wire facp_pkg::facp_area_t   req_area,
  input wire logic                   req_grant_q,
  input wire logic                   req_error_q,
  input wire logic                   lvl_req,
  input wire facp_pkg::facp_level_t  lvl_target,
  input wire logic                   lvl_refused_q,
  input wire logic                   fl_mass_erase_q,
  input wire logic                   fl_opt_write_q,
  input wire logic [7:0]             fl_opt_data_q,
  input wire logic                   fl_done,
  input wire facp_pkg::facp_level_t  level_q,
  input wire logic                   debug_enable_q,
  input wire logic                   busy_q,
  input wire logic                   err_clear
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic tk  = req_valid && req_ready && !lvl_req;
  wire logic dbg = req_source == facp_pkg::FACP_SRC_DEBUG;
  wire logic hi  = level_q == facp_pkg::FACP_LVL_HIGH;
  wire logic mid = level_q == facp_pkg::FACP_LVL_MID;
  sequence s_down;
    lvl_req && !busy_q && mid && lvl_target == facp_pkg::FACP_LVL_LOW;
  endsequence
  sequence s_erase_done;
    fl_mass_erase_q ##[1:40] fl_done;
  endsequence
  chk_mid_dbg_block:
    assert property (tk && mid && dbg && req_area == facp_pkg::FACP_AREA_MAIN |=> req_error_q)
      else $error("debug main access not refused");
  chk_sram_open:
    assert property (tk && req_area == facp_pkg::FACP_AREA_SRAM |=> req_grant_q)
      else $error("sram access refused");
  chk_sys_guard:
    assert property (tk && req_area == facp_pkg::FACP_AREA_SYS
      && req_source != facp_pkg::FACP_SRC_SYSMEM |=> !req_grant_q)
      else $error("system memory granted to foreign code");
  chk_mass_open:
    assert property (tk && req_area == facp_pkg::FACP_AREA_MASS && !hi |=> req_grant_q)
      else $error("mass erase refused");
  chk_hi_no_debug:
    assert property (hi [*2] |-> !debug_enable_q)
      else $error("debug enabled at highest level");
  chk_hi_frozen:
    assert property (lvl_req && !busy_q && hi |=> lvl_refused_q && !fl_opt_write_q)
      else $error("level change from highest not refused");
  chk_down_erase:
    assert property (s_down |=> fl_mass_erase_q && busy_q)
      else $error("downgrade without main erase");
  chk_a5_rewrite:
    assert property (first_match(s_erase_done) |=> fl_opt_write_q && fl_opt_data_q == 8'ha5)
      else $error("no option rewrite after erase");
  chk_err_sticky:
    assert property (req_error_q && !err_clear |=> req_error_q)
      else $error("error flag lost without clear");
endmodule
bind facp_top facp_chk u_facp_chk (.core_clk, .rst, .req_valid, .req_ready, .req_source,
  .req_area, .req_grant_q, .req_error_q, .lvl_req, .lvl_target, .lvl_refused_q,
  .fl_mass_erase_q, .fl_opt_write_q, .fl_opt_data_q, .fl_done, .level_q,
  .debug_enable_q, .busy_q, .err_clear);
`default_nettype wire

// ==== verif/facp_flash_model.sv ====
// facp_flash_model: flash array controller answering each started operation
// assumes: start pulses one cycle; slow stretches the answer
`timescale 1ns/1ps
`default_nettype none
module facp_flash_model (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic slow,
  output logic      fl_done
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != 4'h0)
      cnt_d = cnt_q - 4'h1;
    if (start)
      cnt_d = slow ? 4'h7 : 4'h1;
  end
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  assign fl_done = cnt_q == 4'h1;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// tb_top: permission table and level change checks of facp_top
// assumes: package, design, checker and flash model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'h0, rst = 1'h1, req_valid = 1'h0, lvl_req = 1'h0;
  logic err_clear = 1'h1, slow = 1'h0, req_ready, req_grant_q, req_error_q;
  logic lvl_refused_q, fl_mass_erase_q, fl_opt_write_q, fl_opt_high_q;
  logic fl_done, debug_enable_q, busy_q;
  logic [31:0] req_offset;
  logic [7:0] b1, b2, b3, fl_opt_data_q;
  facp_pkg::facp_source_t req_source;
  facp_pkg::facp_area_t req_area;
  facp_pkg::facp_op_t req_op;
  facp_pkg::facp_level_t lvl_target, level_q;
  int n_fail = 0, total_checks = 0, seed = 75809, cyc = 0;
  facp_top u_facp_top (.core_clk, .rst, .req_valid, .req_source, .req_area, .req_op,
    .req_offset, .req_ready, .req_grant_q, .req_error_q, .lvl_req, .lvl_target,
    .lvl_refused_q, .read_protect_byte_one(b1), .read_protect_byte_two(b2),
    .read_protect_byte_two_complement(b3), .fl_mass_erase_q, .fl_opt_write_q,
    .fl_opt_data_q, .fl_opt_high_q, .fl_done, .level_q, .debug_enable_q, .busy_q,
    .err_clear);
  facp_flash_model u_facp_flash_model (.core_clk, .rst,
    .start(fl_mass_erase_q | fl_opt_write_q), .slow, .fl_done);
  initial forever #5 core_clk = ~core_clk;
  // whole run needs about 420 cycles
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] ex, logic [7:0] got);
    total_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // level 2 keeps first byte a5 to show it is ignored
  task automatic setlv(int l);
    b1 = (l != 1) ? 8'ha5 : 8'h00;
    b2 = (l == 2) ? 8'hcc : 8'h00;
    b3 = (l == 2) ? 8'h33 : 8'h00;
  endtask
  // codes: level 0 low 2 high, source 0 debug 2 sysmem, area 1 mass 2 opt 3 sys 4 sram
  function automatic logic exp_ok(int lv, int s, int a, int o, logic f4);
    if (a == 3'h4) return 1'h1;
    if (a == 3'h3) return s == 2'h2;
    if (lv == 2'h2 && s == 2'h0) return 1'h0;
    if (a == 3'h1) return 1'h1;
    if (a == 3'h2) return lv != 2'h2 || o == 2'h0;
    if (lv == 2'h0) return 1'h1;
    return s != 2'h0 && (!f4 || o == 2'h0);
  endfunction
  task automatic acc(int l, int s, int a, int o, logic [31:0] off);
    logic e;
    req_source = facp_pkg::facp_source_t'(s);
    req_area = facp_pkg::facp_area_t'(a);
    req_op = facp_pkg::facp_op_t'(o);
    req_offset = off;
    req_valid = 1'h1;
    tick();
    e = exp_ok(l, s, a, o, off < 32'h1000);
    chk("grant", e, req_grant_q);
    chk("error", !e, req_error_q);
  endtask
  task automatic lvl(int f, int t);
    int k;
    logic bad;
    bad = f == 2 || f == t;
    lvl_target = facp_pkg::facp_level_t'(t);
    lvl_req = 1'h1;
    tick();
    lvl_req = 1'h0;
    chk("refused", bad, lvl_refused_q);
    chk("busy", !bad, busy_q);
    chk("erase", f == 1 && t == 0, fl_mass_erase_q);
    for (k = 0; k < 40 && busy_q === 1'h1; k++)
    begin
      chk("ready", 0, req_ready);
      if (fl_opt_write_q === 1'h1)
      begin
        chk("opt data", t == 0 ? 8'ha5 : 8'h00, fl_opt_data_q);
        chk("opt high", t == 2, fl_opt_high_q);
      end
      tick();
    end
    chk("level", bad ? f : t, level_q);
    setlv(bad ? f : t);
    tick();
    tick();
  endtask
  initial
  begin
    int l;
    int i;
    setlv(1);
    // an allowed access held during reset must still not be granted
    req_source = facp_pkg::FACP_SRC_DEBUG;
    req_area = facp_pkg::FACP_AREA_SRAM;
    req_op = facp_pkg::FACP_OP_READ;
    req_offset = 32'h0;
    req_valid = 1'h1;
    lvl_target = facp_pkg::facp_level_t'(0);
    repeat (5) tick();
    chk("reset level", 2, level_q);
    chk("reset debug", 0, debug_enable_q);
    chk("reset grant", 0, req_grant_q);
    chk("reset error", 0, req_error_q);
    rst = 1'h0;
    req_valid = 1'h0;
    for (l = 0; l < 3; l++)
    begin
      setlv(l);
      tick();
      tick();
      chk("level", l, level_q);
      chk("debug", l != 2, debug_enable_q);
      for (i = 0; i < 120; i++)
        acc(l, i % 4, (i / 4) % 5, (i / 20) % 3,
          ($random(seed) & 32'h0fff) + (i < 60 ? 32'h0 : 32'h1000));
      $display("done: accesses at level %0d", l);
    end
    err_clear = 1'h0;
    acc(2, 0, 0, 0, 0);
    req_valid = 1'h0;
    tick();
    chk("sticky", 1, req_error_q);
    err_clear = 1'h1;
    tick();
    chk("cleared", 0, req_error_q);
    $display("done: error flag");
    lvl(2, 0);
    setlv(1);
    tick();
    tick();
    lvl(1, 1);
    slow = $random(seed) | 1;
    lvl(1, 0);
    slow = 1'h0;
    lvl(0, 1);
    lvl(1, 2);
    setlv(0);
    tick();
    tick();
    lvl(0, 2);
    $display("done: level changes");
    wrap_up();
  end
endmodule
`default_nettype wire
